// ===== rtl/ifp_pkg.sv
package ifp_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // widths and fixed values
    localparam int          PC_W        = 21;
    localparam int          WORD_W      = 16;
    localparam int          DATA_W      = 8;
    localparam int          DADDR_W     = 12;
    localparam int          PHASES      = 4;            // oscillator divide ratio
    localparam logic [20:0] PC_RESET    = 21'h000000;
    localparam logic [20:0] PC_STEP     = 21'h000002;   // one instruction word in bytes
    localparam logic [11:0] PC_LOW_ADDR = 12'hff9;      // data address of pc_low_byte
    localparam logic [7:0]  WORKING_REG_RESET  = 8'h00;

    ////////////////////////////////////////////////////////////////////////////
    // opcode fields of the first word
    localparam logic [7:0] OPC_JUMP_ABS = 8'hef;        // 1110 1111
    localparam logic [6:0] OPC_CALL_ABS = 7'h76;        // 1110 110s
    localparam logic [7:0] OPC_LOAD_PTR = 8'hee;        // 1110 1110
    localparam logic [4:0] OPC_BRANCH   = 5'h1a;        // 1101 0nnn
    localparam logic [6:0] OPC_SKIP_Z   = 7'h33;        // 0110 011a
    localparam logic [5:0] OPC_ADD_WF   = 6'h09;        // 0010 01da
    localparam logic [7:0] OPC_MOV_LIT  = 8'h0e;        // 0000 1110
    localparam logic [7:0] OPC_RET_LIT  = 8'h0c;        // 0000 1100
    localparam logic [3:0] OPC_MOVE_FF  = 4'hc;         // 1100 ssss
    localparam logic [3:0] OPC_SECOND   = 4'hf;         // top 4 bits of a second word

    ////////////////////////////////////////////////////////////////////////////
    // phases and decoded operations
    typedef enum logic [1:0] {
        PHASE_ONE,
        PHASE_TWO,
        PHASE_THREE,
        PHASE_FOUR
    } ifp_phase_e;

    typedef enum logic [3:0] {
        OP_NOP,
        OP_JUMP_ABS,
        OP_CALL_ABS,
        OP_BRANCH_REL,
        OP_TEST_SKIP_IF_ZERO,
        OP_ADD_WORKING_TO_FILE,
        OP_MOV_LIT,
        OP_RETURN_WITH_LITERAL,
        OP_FILE_TO_FILE_MOVE,
        OP_LOAD_POINTER_LITERAL,
        OP_SECOND_WORD
    } ifp_op_e;

    // data memory request, one strobe per phase
    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [11:0] addr;
        logic [7:0]  wdata;
    } ifp_dm_req_s;

    // pointer load produced by the load_pointer_literal operation
    typedef struct packed {
        logic        load;
        logic [1:0]  sel;
        logic [11:0] value;
    } ifp_ptr_load_s;

endpackage : ifp_pkg

// ===== rtl/ifp_fetch_pipe.sv
// How it works
// - each instruction cycle is four phases, one to four, driving every action
// - next word is fetched while the current one executes, one per cycle
// - a pc change discards the prefetched word, costing one cycle
// - the program counter steps during phase one of each fetch cycle
// - fetched word enters the hold register in phase one, executes in two to four
// - operand read in phase two, destination write in phase four
// - byte addressed program memory, instruction words start at even addresses
// - sequential pc step is 2 and bit zero always reads zero
// - absolute jump and call load the word address into pc bits 20..1
// - relative branch offset counts words, not bytes
// - second words of two-word operations have top four bits set, data below
// - a two-word operation uses the data of its following second word
// - a second word reached on its own executes as a no-operation
// - adding working register to pc low byte jumps forward by that many bytes
// - return with literal returns and places the 8-bit literal in working register
// - phases come from dividing the core clock by four
// - writing pc low byte loads upper bytes from latches; jumps bypass latches
// - register-to-register move takes two words and two cycles
module ifp_fetch_pipe (
    input  wire logic                  clock_i,          // core clock
    input  wire logic                  rst_n_i,          // async reset, active low
    output logic [20:0]                pm_addr_o,        // program memory byte address
    input  wire logic [15:0]           pm_data_i,        // word at pm_addr_o, taken end of phase four
    output ifp_pkg::ifp_dm_req_s       dm_req_o,         // data memory request
    input  wire logic [7:0]            dm_rdata_i,       // read data, valid in phase three
    input  wire logic [3:0]            bank_sel_i,       // bank select for banked access
    input  wire logic [7:0]            pc_high_latch_i,  // pc_high_latch register
    input  wire logic [4:0]            pc_upper_latch_i, // pc_upper_latch register
    input  wire logic [20:0]           ret_addr_i,       // top of return stack
    output logic                       stack_push_o,     // push push_addr_o, one cycle
    output logic [20:0]                push_addr_o,      // return address to push
    output logic                       stack_pop_o,      // pop return stack, one cycle
    output ifp_pkg::ifp_ptr_load_s     ptr_load_o,       // pointer load pulse
    output logic [7:0]                 working_reg_o,    // working_reg contents
    output logic [15:0]                instr_hold_reg_o, // word being executed
    output logic [3:0]                 phase_o           // one-hot phase, bit 0 is phase one
);

    ////////////////////////////////////////////////////////////////////////////
    // decode and address functions
    function automatic ifp_pkg::ifp_op_e decode(input logic [15:0] w);
        ifp_pkg::ifp_op_e op;
        op = ifp_pkg::OP_NOP;
        if (w[15:8] == ifp_pkg::OPC_JUMP_ABS)       op = ifp_pkg::OP_JUMP_ABS;
        else if (w[15:9] == ifp_pkg::OPC_CALL_ABS)  op = ifp_pkg::OP_CALL_ABS;
        else if (w[15:8] == ifp_pkg::OPC_LOAD_PTR)  op = ifp_pkg::OP_LOAD_POINTER_LITERAL;
        else if (w[15:11] == ifp_pkg::OPC_BRANCH)   op = ifp_pkg::OP_BRANCH_REL;
        else if (w[15:9] == ifp_pkg::OPC_SKIP_Z)    op = ifp_pkg::OP_TEST_SKIP_IF_ZERO;
        else if (w[15:10] == ifp_pkg::OPC_ADD_WF)   op = ifp_pkg::OP_ADD_WORKING_TO_FILE;
        else if (w[15:8] == ifp_pkg::OPC_MOV_LIT)   op = ifp_pkg::OP_MOV_LIT;
        else if (w[15:8] == ifp_pkg::OPC_RET_LIT)   op = ifp_pkg::OP_RETURN_WITH_LITERAL;
        else if (w[15:12] == ifp_pkg::OPC_MOVE_FF)  op = ifp_pkg::OP_FILE_TO_FILE_MOVE;
        else if (w[15:12] == ifp_pkg::OPC_SECOND)   op = ifp_pkg::OP_SECOND_WORD;
        return op;
    endfunction : decode

    // file address from the 8-bit field and access bit
    function automatic logic [11:0] file_addr(input logic [15:0] w, input logic [3:0] bank);
        logic [11:0] a;
        a = {bank, w[7:0]};
        if (!w[8]) begin
            a = w[7] ? {4'hf, w[7:0]} : {4'h0, w[7:0]};
        end
        return a;
    endfunction : file_addr

    ////////////////////////////////////////////////////////////////////////////
    // state
    ifp_pkg::ifp_phase_e phase_q;
    ifp_pkg::ifp_op_e    op_q;
    logic [20:0]         pc_q;
    logic [15:0]         pf_word_q;
    logic                pf_valid_q;
    logic [15:0]         ex_word_q;
    logic                ex_valid_q;
    logic [7:0]          working_reg_q;
    logic [7:0]          result_q;
    logic                zero_q;
    logic                move_pend_q;
    logic [7:0]          move_data_q;
    logic                ex_pc_low_q;
    ifp_pkg::ifp_op_e    pf_op;
    logic                redirect;
    logic                skip;
    logic [20:0]         target;
    logic [7:0]          operand;
    logic [8:0]          sum;

    assign pf_op = decode(pf_word_q);

    ////////////////////////////////////////////////////////////////////////////
    // phase divider, four core clocks per instruction cycle
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            phase_q <= ifp_pkg::PHASE_ONE;
            phase_o <= 4'h1;
        end else begin
            case (phase_q)
                ifp_pkg::PHASE_ONE:   phase_q <= ifp_pkg::PHASE_TWO;
                ifp_pkg::PHASE_TWO:   phase_q <= ifp_pkg::PHASE_THREE;
                ifp_pkg::PHASE_THREE: phase_q <= ifp_pkg::PHASE_FOUR;
                ifp_pkg::PHASE_FOUR:  phase_q <= ifp_pkg::PHASE_ONE;
                default:              phase_q <= ifp_pkg::PHASE_ONE;
            endcase
            phase_o <= {phase_o[2:0], phase_o[3]};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // branch decision, evaluated in phase four of the execution cycle
    always_comb begin
        redirect = 1'b0;
        skip     = 1'b0;
        target   = pc_q;
        if (ex_valid_q) begin
            case (op_q)
                ifp_pkg::OP_JUMP_ABS, ifp_pkg::OP_CALL_ABS: begin
                    redirect = 1'b1;
                    target   = {pm_data_i[11:0], ex_word_q[7:0], 1'b0};
                end
                ifp_pkg::OP_BRANCH_REL: begin
                    redirect = 1'b1;
                    target   = pm_addr_o + {{9{ex_word_q[10]}}, ex_word_q[10:0], 1'b0};
                end
                ifp_pkg::OP_ADD_WORKING_TO_FILE: begin
                    if (ex_pc_low_q && ex_word_q[9]) begin
                        redirect = 1'b1;
                        target   = {pc_upper_latch_i, pc_high_latch_i, result_q[7:1], 1'b0};
                    end
                end
                ifp_pkg::OP_RETURN_WITH_LITERAL: begin
                    redirect = 1'b1;
                    target   = {ret_addr_i[20:1], 1'b0};
                end
                ifp_pkg::OP_TEST_SKIP_IF_ZERO: skip = zero_q;
                default: begin
                    redirect = 1'b0;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // program counter and fetch
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pc_q       <= ifp_pkg::PC_RESET;
            pm_addr_o  <= ifp_pkg::PC_RESET;
            pf_word_q  <= 16'h0000;
            pf_valid_q <= 1'b0;
        end else begin
            if (phase_q == ifp_pkg::PHASE_ONE) begin
                pm_addr_o <= pc_q;
                pc_q      <= pc_q + ifp_pkg::PC_STEP;
            end
            if (phase_q == ifp_pkg::PHASE_FOUR) begin
                pf_word_q  <= pm_data_i;
                pf_valid_q <= !(redirect || skip);
                if (redirect) begin
                    pc_q <= target;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // instruction hold register, loaded in phase one
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ex_word_q        <= 16'h0000;
            ex_valid_q       <= 1'b0;
            op_q             <= ifp_pkg::OP_NOP;
            ex_pc_low_q      <= 1'b0;
            instr_hold_reg_o <= 16'h0000;
        end else if (phase_q == ifp_pkg::PHASE_ONE) begin
            ex_word_q        <= pf_word_q;
            instr_hold_reg_o <= pf_word_q;
            ex_valid_q       <= pf_valid_q;
            op_q             <= pf_valid_q ? pf_op : ifp_pkg::OP_NOP;
            ex_pc_low_q      <= file_addr(pf_word_q, bank_sel_i) == ifp_pkg::PC_LOW_ADDR;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // operand arithmetic, pc low byte reads the current fetch address
    assign operand = ex_pc_low_q ? pm_addr_o[7:0] : dm_rdata_i;
    assign sum     = {1'b0, operand} + {1'b0, working_reg_q};

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            result_q    <= 8'h00;
            zero_q      <= 1'b0;
            move_data_q <= 8'h00;
        end else if (phase_q == ifp_pkg::PHASE_THREE) begin
            result_q    <= sum[7:0];
            zero_q      <= operand == 8'h00;
            if (op_q == ifp_pkg::OP_FILE_TO_FILE_MOVE) begin
                move_data_q <= dm_rdata_i;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // data memory strobes: read during phase two, write during phase four
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            dm_req_o <= '0;
        end else begin
            dm_req_o.rd <= 1'b0;
            dm_req_o.wr <= 1'b0;
            if (phase_q == ifp_pkg::PHASE_ONE && pf_valid_q) begin
                case (pf_op)
                    ifp_pkg::OP_TEST_SKIP_IF_ZERO, ifp_pkg::OP_ADD_WORKING_TO_FILE: begin
                        dm_req_o.rd   <= 1'b1;
                        dm_req_o.addr <= file_addr(pf_word_q, bank_sel_i);
                    end
                    ifp_pkg::OP_FILE_TO_FILE_MOVE: begin
                        dm_req_o.rd   <= 1'b1;
                        dm_req_o.addr <= pf_word_q[11:0];
                    end
                    default: dm_req_o.rd <= 1'b0;
                endcase
            end
            if (phase_q == ifp_pkg::PHASE_THREE) begin
                if (op_q == ifp_pkg::OP_ADD_WORKING_TO_FILE && ex_word_q[9] && !ex_pc_low_q) begin
                    dm_req_o.wr    <= 1'b1;
                    dm_req_o.wdata <= sum[7:0];                          // result_q only updates on this edge
                end
                if (op_q == ifp_pkg::OP_SECOND_WORD && move_pend_q) begin
                    dm_req_o.wr    <= 1'b1;
                    dm_req_o.addr  <= ex_word_q[11:0];
                    dm_req_o.wdata <= move_data_q;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // two-word move tracking; a lone second word finds no pending move
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            move_pend_q <= 1'b0;
        end else if (phase_q == ifp_pkg::PHASE_FOUR) begin
            move_pend_q <= op_q == ifp_pkg::OP_FILE_TO_FILE_MOVE;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // working register
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            working_reg_q        <= ifp_pkg::WORKING_REG_RESET;
            working_reg_o <= ifp_pkg::WORKING_REG_RESET;
        end else if (phase_q == ifp_pkg::PHASE_FOUR) begin
            case (op_q)
                ifp_pkg::OP_MOV_LIT, ifp_pkg::OP_RETURN_WITH_LITERAL: begin
                    working_reg_q        <= ex_word_q[7:0];
                    working_reg_o <= ex_word_q[7:0];
                end
                ifp_pkg::OP_ADD_WORKING_TO_FILE: begin
                    if (!ex_word_q[9]) begin
                        working_reg_q        <= result_q;
                        working_reg_o <= result_q;
                    end
                end
                default: working_reg_q <= working_reg_q;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // stack and pointer pulses, one core clock wide after phase four
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            stack_push_o <= 1'b0;
            stack_pop_o  <= 1'b0;
            push_addr_o  <= ifp_pkg::PC_RESET;
            ptr_load_o   <= '0;
        end else begin
            stack_push_o    <= phase_q == ifp_pkg::PHASE_FOUR && op_q == ifp_pkg::OP_CALL_ABS;
            stack_pop_o     <= phase_q == ifp_pkg::PHASE_FOUR && op_q == ifp_pkg::OP_RETURN_WITH_LITERAL;
            ptr_load_o.load <= phase_q == ifp_pkg::PHASE_FOUR && op_q == ifp_pkg::OP_LOAD_POINTER_LITERAL;
            if (phase_q == ifp_pkg::PHASE_FOUR) begin
                push_addr_o      <= pm_addr_o + ifp_pkg::PC_STEP;         // past the second word
                ptr_load_o.sel   <= ex_word_q[5:4];
                ptr_load_o.value <= {ex_word_q[3:0], pm_data_i[7:0]};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // assertions
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);

    a_phase_order: assert property (phase_q == ifp_pkg::PHASE_FOUR |=> phase_q == ifp_pkg::PHASE_ONE ##1
        phase_q == ifp_pkg::PHASE_TWO ##1 phase_q == ifp_pkg::PHASE_THREE ##1 phase_q == ifp_pkg::PHASE_FOUR)
        else $error("phase sequence broken");
    a_pc_step: assert property (phase_q == ifp_pkg::PHASE_ONE |=> pc_q == $past(pc_q) + 21'h000002)
        else $error("pc did not step by two in phase one");
    a_pc_aligned: assert property (!pc_q[0] && !pm_addr_o[0])
        else $error("pc misaligned");
    a_hold_capture: assert property (phase_q == ifp_pkg::PHASE_ONE |=> ex_word_q == $past(pf_word_q))
        else $error("hold register not loaded in phase one");
    a_read_phase: assert property (dm_req_o.rd |-> phase_q == ifp_pkg::PHASE_TWO)
        else $error("data read outside phase two");
    a_write_phase: assert property (dm_req_o.wr |-> phase_q == ifp_pkg::PHASE_FOUR)
        else $error("data write outside phase four");
    a_flush_slot: assert property (phase_q == ifp_pkg::PHASE_FOUR && redirect |=> ##1 !ex_valid_q [*4])
        else $error("slot after branch not flushed");
    a_abs_target: assert property (phase_q == ifp_pkg::PHASE_FOUR && ex_valid_q && op_q == ifp_pkg::OP_JUMP_ABS
        |=> pc_q == {$past(pm_data_i[11:0]), $past(ex_word_q[7:0]), 1'b0})
        else $error("absolute jump target wrong");
    a_lone_second: assert property (phase_q == ifp_pkg::PHASE_ONE && pf_valid_q && pf_op == ifp_pkg::OP_SECOND_WORD
        && !move_pend_q |=> !dm_req_o.wr [*4])
        else $error("lone second word wrote memory");
    a_literal_ret: assert property (phase_q == ifp_pkg::PHASE_FOUR && op_q == ifp_pkg::OP_RETURN_WITH_LITERAL
        |=> working_reg_o == $past(ex_word_q[7:0]) && stack_pop_o)
        else $error("literal return wrong");
    a_reset_slot: assert property ($rose(rst_n_i) |-> !ex_valid_q [*5])
        else $error("first slot not empty");

    c_branch:   cover property (phase_q == ifp_pkg::PHASE_FOUR && redirect && op_q == ifp_pkg::OP_BRANCH_REL);
    c_skip:     cover property (phase_q == ifp_pkg::PHASE_FOUR && skip);
    c_move:     cover property (dm_req_o.wr && move_pend_q);
    c_computed: cover property (phase_q == ifp_pkg::PHASE_FOUR && redirect && ex_pc_low_q);

endmodule : ifp_fetch_pipe

// ===== dv/ifp_mem_model.sv
module ifp_mem_model (
    input  wire logic                 clock_i,    // core clock
    input  wire logic [20:0]          pm_addr_i,  // program byte address
    output logic [15:0]               pm_data_o,  // program word, late after a change
    input  wire ifp_pkg::ifp_dm_req_s dm_req_i,   // data memory request
    output logic [7:0]                dm_rdata_o  // read data, the clock after rd
);
    timeunit 1ns;
    timeprecision 1ns;

    logic [15:0] pm [256];
    logic [7:0]  dm [4096];
    logic [20:0] addr_q;

    ////////////////////////////////////////////////
    // memories start cleared
    initial begin
        for (int i = 0; i < 4096; i++) dm[i] = 8'h00;
        for (int i = 0; i < 256; i++) pm[i] = 16'h0000;
    end

    // word index drops the byte bit; garbage until the address settled a clock
    always @(posedge clock_i) begin
        addr_q <= pm_addr_i;
        pm_data_o <= (pm_addr_i == addr_q) ? pm[pm_addr_i[8:1]] : ~pm_data_o;
    end

    // synchronous data memory; stale data is inverted so it never looks valid
    always @(posedge clock_i) begin
        dm_rdata_o <= dm_req_i.rd ? dm[dm_req_i.addr] : ~dm_rdata_o;
        if (dm_req_i.wr) dm[dm_req_i.addr] <= dm_req_i.wdata;
    end
endmodule : ifp_mem_model

// ===== dv/ifp_fetch_pipe_test.sv
module ifp_fetch_pipe_test;
    timeunit 1ns;
    timeprecision 1ns;

    logic                 clock_i, rst_n_i, push, pop, run_q;
    logic [20:0]          pm_addr, ret_addr, push_addr;
    logic [15:0]          pm_data, ir;
    logic [7:0]           rdata, working_reg, lat_h;
    logic [4:0]           lat_u;
    logic [3:0]           bank;
    logic [20:0]          push_got;  // push address seen with the push pulse
    ifp_pkg::ifp_ptr_load_s ptr, ptr_got;
    logic [3:0]           phase, prev_phase;
    ifp_pkg::ifp_dm_req_s dm_req;
    logic [20:0]          fa [5];
    logic [15:0]          ia [5];
    int                   mismatches, total_checks;
    int                   cnt [4];   // rd, wr, pop, push strobes seen

    ifp_fetch_pipe u_dut (
        .clock_i (clock_i), .rst_n_i (rst_n_i), .pm_addr_o (pm_addr), .pm_data_i (pm_data),
        .dm_req_o (dm_req), .dm_rdata_i (rdata), .bank_sel_i (bank), .pc_high_latch_i (lat_h),
        .pc_upper_latch_i (lat_u), .ret_addr_i (ret_addr), .stack_push_o (push),
        .push_addr_o (push_addr), .stack_pop_o (pop), .ptr_load_o (ptr), .working_reg_o (working_reg),
        .instr_hold_reg_o (ir), .phase_o (phase)
    );

    ifp_mem_model u_mem (
        .clock_i (clock_i), .pm_addr_i (pm_addr), .pm_data_o (pm_data), .dm_req_i (dm_req),
        .dm_rdata_o (rdata)
    );

    ////////////////////////////////////////////////
    // core clock
    initial begin
        clock_i = 1'b0;
        forever #50 clock_i = ~clock_i;
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %0t %s: got %h exp %h", $time, what, got, exp);
        end
    endtask : check

    task automatic finish_test;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : finish_test

    // load program and data, reset, sample fetch address in phase two of five cycles
    task automatic exec(input logic [15:0] w [4], input logic [7:0] d0, input logic [7:0] d16);
        for (int i = 0; i < 256; i++) u_mem.pm[i] = 16'h0000;
        for (int i = 0; i < 4; i++) u_mem.pm[i] = w[i];
        u_mem.dm[0] = d0;
        u_mem.dm[16] = d16;
        u_mem.dm[32] = 8'h00;
        rst_n_i = 1'b0;
        repeat (8) @(negedge clock_i);
        check(phase, 4'h1, "reset phase");
        check(pm_addr, 21'h0, "reset address");
        check(working_reg, 8'h00, "reset working");
        cnt = '{default: 0};
        push_got = '0;
        ptr_got = '0;
        rst_n_i = 1'b1;
        for (int i = 0; i < 5; i++) begin
            @(negedge clock_i);
            fa[i] = pm_addr;
            ia[i] = ir;
            repeat (3) @(negedge clock_i);
        end
    endtask : exec

    task automatic fetch(input logic [20:0] e [5]);
        for (int i = 0; i < 5; i++) check(fa[i], e[i], "fetch address");
    endtask : fetch

    // phase order and data strobe placement, counted strobes
    always @(negedge clock_i) begin
        if (rst_n_i && run_q) check(phase, {prev_phase[2:0], prev_phase[3]}, "phase order");
        if (dm_req.rd === 1'b1) check(phase, 4'h2, "read phase");
        if (dm_req.wr === 1'b1) check(phase, 4'h8, "write phase");
        cnt[0] += int'(dm_req.rd === 1'b1);
        cnt[1] += int'(dm_req.wr === 1'b1);
        cnt[2] += int'(pop === 1'b1);
        cnt[3] += int'(push === 1'b1);
        if (push === 1'b1) push_got = push_addr;
        if (ptr.load === 1'b1) ptr_got = ptr;
        prev_phase = phase;
        run_q = rst_n_i;
    end

    task automatic t_seq;
        exec('{16'h0e11, 16'h0e22, 16'hee25, 16'hf0ab}, 8'h00, 8'h00);
        fetch('{21'h0, 21'h2, 21'h4, 21'h6, 21'h8});
        check(ptr_got, {1'b1, 2'h2, 12'h5ab}, "pointer load");
        check(ia[1], 16'h0e11, "hold word");
        check(ia[2], 16'h0e22, "hold word");
        check(working_reg, 8'h22, "working");
    endtask : t_seq

    // branch by one word lands on an absolute jump, latches nonzero
    task automatic t_branch_jump;
        exec('{16'hd001, 16'h0000, 16'hef10, 16'hf000}, 8'h00, 8'h00);
        fetch('{21'h0, 21'h2, 21'h4, 21'h6, 21'h20});
    endtask : t_branch_jump

    task automatic t_call_ret;
        exec('{16'hec02, 16'hf000, 16'h0c7a, 16'h0000}, 8'h00, 8'h00);
        fetch('{21'h0, 21'h2, 21'h4, 21'h6, 21'h20});
        check(push_got, 21'h4, "push address");
        check(cnt[3], 1, "push count");
        check(cnt[2], 1, "pop count");
        check(working_reg, 8'h7a, "literal");
    endtask : t_call_ret

    task automatic t_computed;
        exec('{16'h0e04, 16'h26f9, 16'h0000, 16'h0000}, 8'h00, 8'h00);
        fetch('{21'h0, 21'h2, 21'h4, 21'h10108, 21'h1010a});
        check(cnt[0], 1, "operand read count");
        check(cnt[1], 0, "no file write");
    endtask : t_computed

    task automatic t_add_file;
        exec('{16'h0e55, 16'h2410, 16'h2610, 16'h0000}, 8'h00, 8'h22);
        check(working_reg, 8'h77, "working sum");
        check(u_mem.dm[16], 8'h99, "file sum");
        check(cnt[0], 2, "read count");
        check(cnt[1], 1, "write count");
    endtask : t_add_file

    task automatic t_move;
        exec('{16'h6600, 16'hc010, 16'hf020, 16'h0000}, 8'h01, 8'h5a);
        fetch('{21'h0, 21'h2, 21'h4, 21'h6, 21'h8});
        check(u_mem.dm[32], 8'h5a, "moved byte");
        check(cnt[1], 1, "write count");
    endtask : t_move

    task automatic t_skip;
        exec('{16'h6600, 16'hc010, 16'hf020, 16'h0000}, 8'h00, 8'h5a);
        check(ia[3], 16'hf020, "lone second word");
        check(u_mem.dm[32], 8'h00, "no move");
        check(cnt[1], 0, "write count");
    endtask : t_skip

    // cut a hang short
    initial begin
        #200000;
        mismatches++;
        finish_test();
    end

    // main sequence
    initial begin
        rst_n_i = 1'b0;
        lat_h = 8'h01;
        lat_u = 5'h01;
        bank = 4'h3;
        ret_addr = 21'h000020;
        @(negedge clock_i);
        t_seq();
        t_branch_jump();
        t_call_ret();
        t_computed();
        t_add_file();
        t_move();
        t_skip();
        finish_test();
    end
endmodule : ifp_fetch_pipe_test
